// ### shared/ssc_defs.svh
// Offsets, field positions, reset values and match constants of the storm suppression control block.
// Assumes inclusion by bare name from the package and the design files; definitions only.
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_ADDR_W 8
`define SSC_CTL_OFS 8'h00
`define SSC_PEN_OFS 8'h10
`define SSC_CNT_OFS 8'h14
`define SSC_CTL_RST 32'h0000_0000
`define SSC_PEN_RST 32'h0000_0000
`define SSC_CNT_RST 32'h0000_0000
`define SSC_CTL_WMASK 32'h0001_FFFF
`define SSC_GAP_BIT 16
`define SSC_B1_RATE_BIT 15
`define SSC_B1_DROP_BIT 14
`define SSC_B1_MASK_LSB 8
`define SSC_B0_RATE_BIT 7
`define SSC_B0_DROP_BIT 6
`define SSC_B0_MASK_LSB 0
`define SSC_CLS_UNI 0
`define SSC_CLS_MC_HIT 1
`define SSC_CLS_BC_LEN 2
`define SSC_CLS_BC_TYPE 3
`define SSC_CLS_RSV_MAC 4
`define SSC_CLS_MISS 5
`define SSC_LEN_TYPE_MIN 16'h0600
`define SSC_RSV_PREFIX 40'h01_80C2_0000
`define SSC_BCAST_DA 48'hFFFF_FFFF_FFFF
`define SSC_RESP_OKAY 2'h0
`define SSC_RESP_SLVERR 2'h2
`endif

// ### shared/ssc_pkg.sv
// Types shared by the storm suppression control block.
// Assumes ssc_defs.svh is on the include path.
`include "ssc_defs.svh"
package ssc_pkg;
	typedef struct packed {
		logic [14:0] rsvd;
		logic gap_in_rate_sel;
		logic b1_rate_mode;
		logic b1_drop_mode;
		logic [5:0] b1_class_mask;
		logic b0_rate_mode;
		logic b0_drop_mode;
		logic [5:0] b0_class_mask;
	} ssc_ctl_s;
	typedef struct packed {
		logic valid;
		logic [4:0] port;
		logic [47:0] da;
		logic [15:0] len_type;
		logic lookup_hit;
		logic full_duplex;
		logic over_b0;
		logic over_b1;
	} ssc_frame_s;
	typedef struct packed {
		logic valid;
		logic [4:0] port;
		logic [5:0] cls;
		logic charge_b0;
		logic charge_b1;
		logic drop;
		logic pause;
		logic jam;
	} ssc_verdict_s;
	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} ssc_wr_s;
	function automatic logic ssc_mapped(input logic [7:0] a);
		return (a == `SSC_CTL_OFS) || (a == `SSC_PEN_OFS) || (a == `SSC_CNT_OFS);
	endfunction
endpackage

// ### src/ssc_classify.sv
// Frame classifier: maps a frame's header facts onto the six suppression classes.
// Assumes the destination address has its first octet in bits 47:40; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"
module ssc_classify (
	input wire logic [47:0] da, // Destination address.
	input wire logic [15:0] len_type, // Length/type field.
	input wire logic lookup_hit, // Destination lookup succeeded.
	output logic [5:0] cls // One bit per class.
);
	logic bcast;
	logic grp;
	always_comb begin
		bcast = (da == `SSC_BCAST_DA);
		grp = da[40];
		cls = 6'h00;
		cls[`SSC_CLS_UNI] = !grp;
		cls[`SSC_CLS_MC_HIT] = grp && !bcast && lookup_hit;
		cls[`SSC_CLS_BC_LEN] = bcast && (len_type < `SSC_LEN_TYPE_MIN);
		cls[`SSC_CLS_BC_TYPE] = bcast && (len_type >= `SSC_LEN_TYPE_MIN);
		cls[`SSC_CLS_RSV_MAC] = (da[47:8] == `SSC_RSV_PREFIX);
		cls[`SSC_CLS_MISS] = !lookup_hit;
	end
endmodule // ssc_classify
`default_nettype wire

// ### src/ssc_axil.sv
// AXI4-Lite slave front end: buffers write address and data, answers reads one cycle after acceptance.
// Assumes one clock and a synchronous active-low reset; register storage lives in the parent.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"
module ssc_axil (
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Synchronous reset, low active.
	input wire logic [7:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output ssc_pkg::ssc_wr_s wr_o, // Register write strobe.
	output logic [7:0] rd_addr_o, // Register read address.
	input wire logic [31:0] rd_data_i // Register read data.
);
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic fire;
	assign fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_o = '{en: fire, addr: aw_addr_reg, data: w_data_reg, strb: w_strb_reg};
	assign rd_addr_o = s_axi_araddr;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SSC_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (fire) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= ssc_pkg::ssc_mapped(aw_addr_reg) ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SSC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= ssc_pkg::ssc_mapped(s_axi_araddr) ? rd_data_i : 32'h0000_0000;
			s_axi_rresp <= ssc_pkg::ssc_mapped(s_axi_araddr) ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // ssc_axil
`default_nettype wire

// ### src/ssc_storm_ctl.sv
// Storm suppression control: the global control word, per-port enables, a drop counter,
// and the per-frame verdict that charges the two rate buckets and picks drop or flow control.
// Assumes frame facts and bucket over-rate flags come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "ssc_defs.svh"
// Operation
// - Gap-inclusion bit makes meter count interframe gap.
// - Bucket 1 rate bit low: absolute rate.
// - Bucket 1 rate bit high: link-speed relative rate.
// - Bucket 0 rate bit picks absolute or relative.
// - Drop bit low: pause full duplex, jam half.
// - Drop bit high: discard monitored over-rate packets.
// - Bucket 1 meters classes set in bits 13:8.
// - Bucket 0 meters classes set in bits 5:0.
// - Class 0 unicast, class 1 multicast lookup hit.
// - Classes 2,3 broadcast below/at or above 0x0600 type.
// - Class 4 reserved bridge-group destination range.
// - Class 5 destination lookup failed.
// - Suppression only on ports with enable set.
module ssc_storm_ctl #(
	parameter int NPORTS = 16
) (
	input wire logic aclk, // Clock, 40 MHz.
	input wire logic aresetn, // Synchronous reset, low active.
	input wire logic [7:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire ssc_pkg::ssc_frame_s frame_i, // Received frame facts.
	output ssc_pkg::ssc_verdict_s verdict_o, // Per-frame verdict.
	output logic gap_in_rate_sel, // Meters include interframe gap.
	output logic b0_rate_mode, // Bucket 0 rate relative to link speed.
	output logic b1_rate_mode // Bucket 1 rate relative to link speed.
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (NPORTS < 1 || NPORTS > 32) begin : g_bad_nports
		$error("NPORTS must lie between 1 and 32.");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	ssc_pkg::ssc_ctl_s ctl_reg;
	logic [NPORTS-1:0] pen_reg;
	logic [31:0] drop_cnt_reg;
	ssc_pkg::ssc_verdict_s verdict_next;
	ssc_pkg::ssc_wr_s wr;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic [5:0] cls;
	logic [31:0] pen_wide;
	logic port_on;
	logic hit_b0;
	logic hit_b1;
	logic over0;
	logic over1;
	logic want_fc;

	// Merges write data into a register under byte strobes and a writable-bit mask.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] wmask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
		return (old & ~m) | (data & m);
	endfunction

	// ----------------------------------------------------------------
	// Bus slave and classifier
	// ----------------------------------------------------------------
	ssc_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_o(wr),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data)
	);

	ssc_classify u_cls (
		.da(frame_i.da),
		.len_type(frame_i.len_type),
		.lookup_hit(frame_i.lookup_hit),
		.cls(cls)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_reg <= `SSC_CTL_RST;
		end else if (wr.en && wr.addr == `SSC_CTL_OFS) begin
			ctl_reg <= merge(ctl_reg, wr.data, wr.strb, `SSC_CTL_WMASK);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pen_reg <= NPORTS'(`SSC_PEN_RST);
		end else if (wr.en && wr.addr == `SSC_PEN_OFS) begin
			pen_reg <= NPORTS'(merge(32'(pen_reg), wr.data, wr.strb, 32'(({NPORTS{1'b1}}))));
		end
	end

	// A drop in the same cycle as a clearing write is kept, so the count restarts at one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drop_cnt_reg <= `SSC_CNT_RST;
		end else if (wr.en && wr.addr == `SSC_CNT_OFS) begin
			drop_cnt_reg <= {31'h0000_0000, verdict_o.valid && verdict_o.drop};
		end else if (verdict_o.valid && verdict_o.drop) begin
			drop_cnt_reg <= drop_cnt_reg + 32'h0000_0001;
		end
	end

	always_comb begin
		case (rd_addr)
			`SSC_CTL_OFS: rd_data = ctl_reg;
			`SSC_PEN_OFS: rd_data = 32'(pen_reg);
			`SSC_CNT_OFS: rd_data = drop_cnt_reg;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	assign gap_in_rate_sel = ctl_reg.gap_in_rate_sel;
	assign b0_rate_mode = ctl_reg.b0_rate_mode;
	assign b1_rate_mode = ctl_reg.b1_rate_mode;

	// ----------------------------------------------------------------
	// Per-frame verdict
	// ----------------------------------------------------------------
	// A bucket is charged when the port is enabled and any enabled class matches.
	// Drop and flow control are decided per bucket; both may apply to one frame.
	always_comb begin
		pen_wide = 32'(pen_reg);
		port_on = pen_wide[frame_i.port];
		hit_b0 = port_on && |(cls & ctl_reg.b0_class_mask);
		hit_b1 = port_on && |(cls & ctl_reg.b1_class_mask);
		over0 = hit_b0 && frame_i.over_b0;
		over1 = hit_b1 && frame_i.over_b1;
		want_fc = (over0 && !ctl_reg.b0_drop_mode) || (over1 && !ctl_reg.b1_drop_mode);
		verdict_next = '0;
		if (frame_i.valid) begin
			verdict_next.valid = 1'b1;
			verdict_next.port = frame_i.port;
			verdict_next.cls = cls;
			verdict_next.charge_b0 = hit_b0;
			verdict_next.charge_b1 = hit_b1;
			verdict_next.drop = (over0 && ctl_reg.b0_drop_mode) || (over1 && ctl_reg.b1_drop_mode);
			verdict_next.pause = want_fc && frame_i.full_duplex;
			verdict_next.jam = want_fc && !frame_i.full_duplex;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			verdict_o <= '0;
		end else begin
			verdict_o <= verdict_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_ctl_wr(int lane);
		wr.en && wr.addr == `SSC_CTL_OFS && wr.strb[lane];
	endsequence

	sequence s_frame_b0_over;
		frame_i.valid && port_on && |(cls & ctl_reg.b0_class_mask) && frame_i.over_b0;
	endsequence

	sequence s_frame_b1_over;
		frame_i.valid && port_on && |(cls & ctl_reg.b1_class_mask) && frame_i.over_b1;
	endsequence

	property p_gap_sel;
		s_ctl_wr(2) |=> gap_in_rate_sel == $past(wr.data[`SSC_GAP_BIT]);
	endproperty
	a_gap_sel: assert property (p_gap_sel) else $error("Gap selection not taken from write.");

	property p_b1_abs;
		s_ctl_wr(1) and !wr.data[`SSC_B1_RATE_BIT] |=> !b1_rate_mode;
	endproperty
	a_b1_abs: assert property (p_b1_abs) else $error("Bucket 1 not absolute after clearing.");

	property p_b1_rel;
		s_ctl_wr(1) and wr.data[`SSC_B1_RATE_BIT] |=> b1_rate_mode ##1 b1_rate_mode || $past(wr.en);
	endproperty
	a_b1_rel: assert property (p_b1_rel) else $error("Bucket 1 not relative after setting.");

	property p_b0_rate;
		s_ctl_wr(0) |=> b0_rate_mode == $past(wr.data[`SSC_B0_RATE_BIT]);
	endproperty
	a_b0_rate: assert property (p_b0_rate) else $error("Bucket 0 rate mode not taken.");

	property p_flow_ctl;
		s_frame_b0_over and !ctl_reg.b0_drop_mode
			|=> verdict_o.pause == $past(frame_i.full_duplex) && verdict_o.jam != verdict_o.pause;
	endproperty
	a_flow_ctl: assert property (p_flow_ctl) else $error("Flow control not chosen by duplex.");

	property p_drop;
		s_frame_b1_over and ctl_reg.b1_drop_mode |=> verdict_o.valid && verdict_o.drop;
	endproperty
	a_drop: assert property (p_drop) else $error("Over-rate frame not dropped.");

	property p_b1_exempt;
		frame_i.valid && (cls & ctl_reg.b1_class_mask) == 6'h00 |=> !verdict_o.charge_b1;
	endproperty
	a_b1_exempt: assert property (p_b1_exempt) else $error("Bucket 1 charged for exempt class.");

	property p_b0_exempt;
		frame_i.valid && (cls & ctl_reg.b0_class_mask) == 6'h00 |=> !verdict_o.charge_b0 && !verdict_o.drop
			|| verdict_o.charge_b1;
	endproperty
	a_b0_exempt: assert property (p_b0_exempt) else $error("Bucket 0 charged for exempt class.");

	property p_unicast;
		frame_i.valid |=> verdict_o.cls[`SSC_CLS_UNI] == !$past(frame_i.da[40]);
	endproperty
	a_unicast: assert property (p_unicast) else $error("Unicast class wrong.");

	property p_bcast_len;
		frame_i.valid && frame_i.da == `SSC_BCAST_DA
			|=> verdict_o.cls[`SSC_CLS_BC_TYPE] == ($past(frame_i.len_type) >= `SSC_LEN_TYPE_MIN)
			&& verdict_o.cls[`SSC_CLS_BC_LEN] != verdict_o.cls[`SSC_CLS_BC_TYPE];
	endproperty
	a_bcast_len: assert property (p_bcast_len) else $error("Broadcast length class wrong.");

	property p_rsv_mac;
		frame_i.valid && frame_i.da[47:8] == `SSC_RSV_PREFIX |=> verdict_o.cls[`SSC_CLS_RSV_MAC];
	endproperty
	a_rsv_mac: assert property (p_rsv_mac) else $error("Reserved address class missed.");

	property p_miss;
		frame_i.valid |=> verdict_o.cls[`SSC_CLS_MISS] == !$past(frame_i.lookup_hit);
	endproperty
	a_miss: assert property (p_miss) else $error("Lookup-failed class wrong.");

	property p_port_off;
		frame_i.valid && !port_on |=> !verdict_o.charge_b0 && !verdict_o.charge_b1 && !verdict_o.drop;
	endproperty
	a_port_off: assert property (p_port_off) else $error("Disabled port was suppressed.");

	property p_reset_zero;
		$rose(aresetn) |-> ctl_reg == `SSC_CTL_RST && pen_reg == '0 && !verdict_o.valid;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("State not zero after reset.");

	property p_upper_zero;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `SSC_CTL_OFS |=> s_axi_rdata[31:17] == 15'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("Reserved control bits read nonzero.");

	property p_charge;
		frame_i.valid && port_on && |(cls & ctl_reg.b1_class_mask) |=> verdict_o.charge_b1;
	endproperty
	a_charge: assert property (p_charge) else $error("Matching frame not charged.");

	property p_charge_b0;
		frame_i.valid && port_on && |(cls & ctl_reg.b0_class_mask) |=> verdict_o.charge_b0;
	endproperty
	a_charge_b0: assert property (p_charge_b0) else $error("Matching frame not charged to bucket 0.");

	property p_b0_drop;
		s_frame_b0_over and ctl_reg.b0_drop_mode |=> verdict_o.valid && verdict_o.drop;
	endproperty
	a_b0_drop: assert property (p_b0_drop) else $error("Bucket 0 over-rate frame not dropped.");

	property p_b1_flow;
		s_frame_b1_over and !ctl_reg.b1_drop_mode |=> verdict_o.pause != verdict_o.jam;
	endproperty
	a_b1_flow: assert property (p_b1_flow) else $error("Bucket 1 flow control not chosen by duplex.");

	property p_quiet;
		frame_i.valid && !frame_i.over_b0 && !frame_i.over_b1
			|=> !verdict_o.drop && !verdict_o.pause && !verdict_o.jam;
	endproperty
	a_quiet: assert property (p_quiet) else $error("Frame under its allowance was suppressed.");

	property p_mc_hit;
		frame_i.valid |=> verdict_o.cls[`SSC_CLS_MC_HIT] == ($past(frame_i.da[40])
			&& $past(frame_i.da) != `SSC_BCAST_DA && $past(frame_i.lookup_hit));
	endproperty
	a_mc_hit: assert property (p_mc_hit) else $error("Multicast class wrong.");

	property p_bcast_only;
		frame_i.valid && frame_i.da != `SSC_BCAST_DA |=> !verdict_o.cls[`SSC_CLS_BC_LEN] && !verdict_o.cls[`SSC_CLS_BC_TYPE];
	endproperty
	a_bcast_only: assert property (p_bcast_only) else $error("Broadcast class on other frame.");

	property p_rsv_other;
		frame_i.valid && frame_i.da[47:8] != `SSC_RSV_PREFIX |=> !verdict_o.cls[`SSC_CLS_RSV_MAC];
	endproperty
	a_rsv_other: assert property (p_rsv_other) else $error("Reserved address class on other frame.");

	property p_idle;
		!frame_i.valid |=> verdict_o == '0;
	endproperty
	a_idle: assert property (p_idle) else $error("Verdict shown without a frame.");

	property p_other_wr;
		wr.en && wr.addr != `SSC_CTL_OFS |=> $stable(ctl_reg);
	endproperty
	a_other_wr: assert property (p_other_wr) else $error("Control word changed by another write.");

	property p_b1_mask;
		s_ctl_wr(1) |=> ctl_reg.b1_class_mask == $past(wr.data[`SSC_B1_MASK_LSB +: 6]);
	endproperty
	a_b1_mask: assert property (p_b1_mask) else $error("Bucket 1 mask not taken from write.");

	property p_b0_mask;
		s_ctl_wr(0) |=> ctl_reg.b0_class_mask == $past(wr.data[`SSC_B0_MASK_LSB +: 6]);
	endproperty
	a_b0_mask: assert property (p_b0_mask) else $error("Bucket 0 mask not taken from write.");
endmodule // ssc_storm_ctl
`default_nettype wire

// ### sim/tb.sv
// Self-checking testbench for the storm suppression control block.
// Assumes ssc_pkg is compiled first and drives the block alone through AXI4-Lite and the frame port.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	ssc_pkg::ssc_frame_s frame_i = '0;
	ssc_pkg::ssc_verdict_s verdict;
	logic gap_in_rate_sel;
	logic b0_rate_mode;
	logic b1_rate_mode;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [31:0] ctl_now = 32'h0000_0000;
	// ----------------------------------------
	// Frame table: destination, length/type, lookup result, expected classes
	// ----------------------------------------
	logic [47:0] fda [6] = '{48'h0011_2233_4455, 48'h0100_5E00_0001, 48'hFFFF_FFFF_FFFF,
		48'hFFFF_FFFF_FFFF, 48'h0180_C200_000E, 48'h0011_2233_4466};
	logic [15:0] flt [6] = '{16'h0800, 16'h0800, 16'h05FF, 16'h0600, 16'h0027, 16'h0800};
	logic fhit [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [5:0] fcls [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h30, 6'h21};

	always #12.5 aclk = ~aclk;

	ssc_storm_ctl #(.NPORTS(16)) i_ssc_storm_ctl (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_i(frame_i), .verdict_o(verdict),
		.gap_in_rate_sel(gap_in_rate_sel), .b0_rate_mode(b0_rate_mode), .b1_rate_mode(b1_rate_mode)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		if (n_fail == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask

	// Address and data are offered together; each is released at the edge that takes it.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, ed);
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	task automatic wr_ctl(input logic [31:0] d);
		axi_wr(8'h00, d, 4'hF, 2'h0);
		ctl_now = d & 32'h0001_FFFF;
	endtask

	// Expected verdict worked out from the control word, the port enable and the meter flags.
	function automatic logic [31:0] expv(input logic [5:0] c, input logic en, input logic o0, input logic o1,
		input logic fd);
		ssc_pkg::ssc_verdict_s v;
		logic fl;
		v = '0;
		v.valid = 1'b1;
		v.port = 5'h03;
		v.cls = c;
		v.charge_b0 = en & (|(c & ctl_now[5:0]));
		v.charge_b1 = en & (|(c & ctl_now[13:8]));
		v.drop = (v.charge_b0 & o0 & ctl_now[6]) | (v.charge_b1 & o1 & ctl_now[14]);
		fl = (v.charge_b0 & o0 & ~ctl_now[6]) | (v.charge_b1 & o1 & ~ctl_now[14]);
		v.pause = fl & fd;
		v.jam = fl & ~fd;
		return 32'(v);
	endfunction

	task automatic send(input int j, input logic o0, input logic o1, input logic fd, input logic en);
		ssc_pkg::ssc_frame_s f;
		f = '0;
		f.valid = 1'b1;
		f.port = 5'h03;
		f.da = fda[j];
		f.len_type = flt[j];
		f.lookup_hit = fhit[j];
		f.full_duplex = fd;
		f.over_b0 = o0;
		f.over_b1 = o1;
		@(posedge aclk);
		frame_i <= f;
		@(posedge aclk);
		frame_i <= '0;
		#1;
		check("verdict", 32'(verdict), expv(fcls[j], en, o0, o1, fd));
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(8'h00, 32'h0000_0000, 2'h0);
		axi_rd(8'h10, 32'h0000_0000, 2'h0);
		axi_rd(8'h14, 32'h0000_0000, 2'h0);
		check("gap_sel", {31'h0, gap_in_rate_sel}, 32'h0);
		wr_ctl(32'hFFFF_FFFF);
		axi_rd(8'h00, 32'h0001_FFFF, 2'h0);
		check("gap_sel", {31'h0, gap_in_rate_sel}, 32'h1);
		check("b1_rate", {31'h0, b1_rate_mode}, 32'h1);
		check("b0_rate", {31'h0, b0_rate_mode}, 32'h1);
		wr_ctl(32'h0000_0000);
		check("b1_rate", {31'h0, b1_rate_mode}, 32'h0);
		check("b0_rate", {31'h0, b0_rate_mode}, 32'h0);
		axi_wr(8'h00, 32'h0001_8080, 4'h4, 2'h0);
		axi_rd(8'h00, 32'h0001_0000, 2'h0);
		check("gap_sel", {31'h0, gap_in_rate_sel}, 32'h1);
		check("b1_rate", {31'h0, b1_rate_mode}, 32'h0);
		axi_wr(8'h04, 32'hFFFF_FFFF, 4'hF, 2'h2);
		axi_rd(8'h04, 32'h0000_0000, 2'h2);
		// Full masks but the port is not enabled, so nothing is charged.
		wr_ctl(32'h0000_3F3F);
		send(0, 1'b1, 1'b1, 1'b1, 1'b0);
		axi_wr(8'h10, 32'h0000_0008, 4'hF, 2'h0);
		axi_rd(8'h10, 32'h0000_0008, 2'h0);
		// One class per pass in bucket 0, all the others in bucket 1.
		for (int i = 0; i < 6; i++) begin
			wr_ctl({18'h0, ~(6'h01 << i), 2'h0, 6'h01 << i});
			for (int j = 0; j < 6; j++) begin
				send(j, 1'b0, 1'b0, 1'b1, 1'b1);
			end
		end
		@(posedge aclk);
		#1;
		check("verdict_idle", 32'(verdict), 32'h0);
		// Bucket 0 drops and bucket 1 sends flow control, then bucket 1 drops and bucket 0 sends flow control.
		wr_ctl(32'h0000_3F7F);
		for (int k = 0; k < 8; k++) begin
			send(0, k[0], k[1], k[2], 1'b1);
		end
		axi_rd(8'h14, 32'h0000_0004, 2'h0);
		wr_ctl(32'h0000_7F3F);
		for (int k = 0; k < 8; k++) begin
			send(5, k[0], k[1], k[2], 1'b1);
		end
		axi_rd(8'h14, 32'h0000_0008, 2'h0);
		axi_wr(8'h14, 32'h0000_0000, 4'hF, 2'h0);
		axi_rd(8'h14, 32'h0000_0000, 2'h0);
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
